// File: hw/muxed_bus_split_and_decode.sv
// Bus cycle generator driving a multiplexed address/data bus
`include "bus_consts.svh"

module muxed_bus_split_and_decode #(
    parameter int HALF_T_CYC = `HALF_T_CYC
) (
    input  wire logic          ref_clk,          // System clock
    input  wire logic          rst_n,            // Async reset
    input  wire logic          req_valid,        // Transfer request
    output logic               req_ready,        // Request taken
    input  wire bus_pkg::req_t req,              // Request contents
    output logic               rsp_valid,        // Transfer finished
    output logic [7:0]         rsp_rdata,        // Read data
    input  wire logic          wait_n,           // Slow device extend
    input  wire logic          bus_hold_request, // Bus wanted by other master
    output logic               bus_grant_ack,    // Bus released
    input  wire logic [7:0]    ad_i,             // Shared lines in
    output bus_pkg::pins_t     pins              // Bus pin drive
);
    import bus_pkg::*;

    // Divider cannot serve a zero or over-wide half T-state
    if (HALF_T_CYC < 1 || HALF_T_CYC > `HALF_T_MAX) begin
        $error("HALF_T_CYC out of range");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_T_CYC - 1);

    state_t r;
    state_t n;
    logic   tick;

    function automatic logic [3:0] strobe_halves(input req_t q);
        logic [3:0] h;
        // Fetch: half T-state less access
        h = q.fetch ? `STB_FETCH_H : `STB_MEM_H;
        // I/O always carries one extra T-state
        if (q.io) begin
            h = h + `IO_WAIT_H;
        end
        return h;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n           = r;
        n.rsp_valid = 1'b0;
        tick        = (r.div == HALF_LAST);
        if (r.st != PH_IDLE && r.st != PH_HOLD) begin
            n.div = tick ? 8'h00 : r.div + 8'h01;
        end
        unique case (r.st)
            PH_IDLE: begin
                n.div = 8'h00;
                if (bus_hold_request) begin
                    n.st          = PH_HOLD;
                    n.grant       = 1'b1;
                    n.pins.ad_oe   = 1'b0;
                    n.pins.a_hi_oe = 1'b0;
                    n.pins.ctl_oe  = 1'b0;
                    n.pins.ale     = 1'b0;
                end else if (req_valid) begin
                    n.lat = req;
                    if (req.io) begin
                        n.lat.addr  = {req.addr[7:0], req.addr[7:0]};
                        n.lat.fetch = 1'b0;
                    end
                    n.pins.a_hi_o  = n.lat.addr[15:8];
                    n.pins.a_hi_oe = 1'b1;
                    n.pins.ad_o    = n.lat.addr[7:0];
                    n.pins.ad_oe   = 1'b1;
                    n.pins.ale     = 1'b1;
                    n.pins.io_m    = req.io;
                    n.pins.ctl_oe  = 1'b1;
                    n.st           = PH_ALE;
                end
            end
            PH_ALE: begin
                if (tick) begin
                    n.pins.ale = 1'b0;
                    n.st       = PH_LATCH;
                end
            end
            PH_LATCH: begin
                if (tick) begin
                    n.half = 4'h0;
                    n.ext  = 1'b0;
                    n.st   = PH_STROBE;
                    if (r.lat.write) begin
                        n.pins.wr_n = 1'b0;
                        n.pins.ad_o = r.lat.wdata;
                    end else begin
                        n.pins.rd_n  = 1'b0;
                        n.pins.ad_oe = 1'b0;
                    end
                end
            end
            PH_STROBE: begin
                if (tick) begin
                    n.half = r.half + 4'h1;
                    if (r.half + 4'h1 == strobe_halves(r.lat)) begin
                        if (!wait_n) begin
                            n.half = r.half - 4'h1;
                            n.ext  = 1'b1;
                        end else begin
                            n.pins.rd_n = 1'b1;
                            n.pins.wr_n = 1'b1;
                            n.rsp_valid = 1'b1;
                            if (!r.lat.write) begin
                                n.rdata = ad_i;
                            end
                            n.st = PH_DONE;
                        end
                    end
                end
            end
            PH_DONE: begin
                // Write data held half a T-state past strobe
                if (tick) begin
                    n.pins.ad_oe = 1'b0;
                    n.st         = PH_IDLE;
                end
            end
            PH_HOLD: begin
                if (!bus_hold_request) begin
                    n.grant        = 1'b0;
                    n.pins.a_hi_oe = 1'b1;
                    n.pins.ctl_oe  = 1'b1;
                    n.st           = PH_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Bus floats and strobes idle while in reset
            r           <= '0;
            r.st        <= PH_IDLE;
            r.pins.rd_n <= 1'b1;
            r.pins.wr_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign req_ready     = (r.st == PH_IDLE) && !bus_hold_request;
    assign rsp_valid     = r.rsp_valid;
    assign rsp_rdata     = r.rdata;
    assign bus_grant_ack = r.grant;
    assign pins          = r.pins;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [15:0] rd_low_cnt;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_low_cnt <= 16'h0000;
        end else if (r.pins.ale) begin
            rd_low_cnt <= 16'h0000;
        end else if (!r.pins.rd_n) begin
            rd_low_cnt <= rd_low_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_addr_out;
        pins.ale && pins.ad_oe && pins.a_hi_oe;
    endsequence

    sequence s_strobe_on;
        !pins.rd_n || !pins.wr_n;
    endsequence

    property p_hi_addr;
        (!pins.rd_n || !pins.wr_n || pins.ale) |-> pins.a_hi_oe
            && pins.a_hi_o == r.lat.addr[15:8];
    endproperty
    a_hi_addr: assert property (p_hi_addr) else $error("high address lost");

    property p_mux_order;
        $rose(pins.ale) |-> s_addr_out ##[1:300] s_strobe_on;
    endproperty
    a_mux_order: assert property (p_mux_order) else $error("no strobe after address");

    property p_read_float;
        !pins.rd_n |-> !pins.ad_oe;
    endproperty
    a_read_float: assert property (p_read_float) else $error("read drives AD");

    property p_mem_addr;
        ($rose(pins.ale) && !pins.io_m) |-> {pins.a_hi_o, pins.ad_o} == $past(req.addr);
    endproperty
    a_mem_addr: assert property (p_mem_addr) else $error("memory address wrong");

    property p_ale_fall;
        $fell(pins.ale) |-> pins.ad_oe && pins.ad_o == $past(pins.ad_o);
    endproperty
    a_ale_fall: assert property (p_ale_fall) else $error("AD changed at ALE fall");

    property p_hold_float;
        bus_grant_ack |-> !pins.ad_oe && !pins.a_hi_oe && !pins.ctl_oe;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("bus driven in hold");

    property p_strobe_after;
        ($fell(pins.rd_n) || $fell(pins.wr_n)) |-> $past(!pins.ale && pins.ad_oe);
    endproperty
    a_strobe_after: assert property (p_strobe_after) else $error("strobe without address");

    property p_fetch_len;
        ($rose(pins.rd_n) && !r.ext && r.lat.fetch)
            |-> rd_low_cnt == 16'(HALF_T_CYC * `STB_FETCH_H);
    endproperty
    a_fetch_len: assert property (p_fetch_len) else $error("fetch strobe length");

    property p_read_len;
        ($rose(pins.rd_n) && !r.ext && !r.lat.fetch && !r.lat.io)
            |-> rd_low_cnt == 16'(HALF_T_CYC * `STB_MEM_H);
    endproperty
    a_read_len: assert property (p_read_len) else $error("read strobe length");

    property p_io_m;
        (s_strobe_on or pins.ale) |-> pins.io_m == r.lat.io;
    endproperty
    a_io_m: assert property (p_io_m) else $error("io_m wrong kind");

    property p_io_dup;
        ($fell(pins.ale) && pins.io_m) |-> pins.a_hi_o == pins.ad_o;
    endproperty
    a_io_dup: assert property (p_io_dup) else $error("port not duplicated");

endmodule

// File: pkg/bus_consts.svh
// Constants for the multiplexed bus cycle generator
`ifndef BUS_CONSTS_SVH
`define BUS_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_NS        10
`define T_STATE_NS    200
`define HALF_T_CYC    ((`T_STATE_NS / 2) / `CLK_NS)
`define HALF_T_MAX    255

// ****************************************************************
// Strobe lengths in half T-states
// ****************************************************************
`define STB_MEM_H     4'h4
`define STB_FETCH_H   4'h3
`define IO_WAIT_H     4'h2

`endif

// File: pkg/bus_pkg.sv
// Types for the multiplexed bus cycle generator
package bus_pkg;

    typedef struct packed {
        logic [15:0] addr;   // Byte address, or port in low byte
        logic [7:0]  wdata;  // Write data
        logic        write;  // 1 write, 0 read
        logic        io;     // 1 I/O transfer, 0 memory
        logic        fetch;  // Opcode fetch (memory read)
    } req_t;

    typedef struct packed {
        logic [7:0] ad_o;    // Shared address/data out
        logic       ad_oe;   // Shared lines driven
        logic [7:0] a_hi_o;  // High address out
        logic       a_hi_oe; // High address driven
        logic       ale;     // Address latch strobe
        logic       rd_n;    // Read strobe
        logic       wr_n;    // Write strobe
        logic       io_m;    // I/O versus memory
        logic       ctl_oe;  // Control strobes driven
    } pins_t;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ALE,
        PH_LATCH,
        PH_STROBE,
        PH_DONE,
        PH_HOLD
    } phase_t;

    typedef struct packed {
        phase_t     st;
        logic [7:0] div;
        logic [3:0] half;
        logic       ext;
        req_t       lat;
        pins_t      pins;
        logic [7:0] rdata;
        logic       rsp_valid;
        logic       grant;
    } state_t;

endpackage

// File: sim/bus_partner.sv
// Behavioural memory and I/O space on the far side of the bus
module bus_partner (
    input  wire bus_pkg::pins_t pins,          // Bus pins from the block
    input  wire logic           ref_clk,       // System clock
    input  wire logic           bus_grant_ack, // Block has released the bus
    output logic [7:0]          ad_i,          // Shared lines toward the block
    output logic [7:0]          mem_sel_n,     // Decoded 1K memory selects
    output logic                lin_sel_n      // Select from two address bits
);
    timeunit 1ns;
    timeprecision 1ns;
    import bus_pkg::*;

    logic [7:0]  mem [0:65535];
    logic [7:0]  io [0:255];
    logic [7:0]  lo_r;
    logic [7:0]  last_r = 8'h00;
    logic [15:0] addr;
    logic        drv_en;

    // outside drivers float while the bus is granted away
    assign drv_en = pins.ctl_oe && !bus_grant_ack;

    // latch open while ale high, then holds
    always_ff @(posedge ref_clk) if (pins.ale) lo_r <= pins.ad_o;
    // high address buffer only ever points outward
    assign addr = {pins.a_hi_o, pins.ale ? pins.ad_o : lo_r};

    // one 1K select in the low 8K, memory cycles only
    always_comb begin
        mem_sel_n = 8'hff;
        if (drv_en && !pins.io_m && addr[15:13] == 3'b000) begin
            mem_sel_n[addr[12:10]] = 1'b0;
        end
    end

    // linear select: every range with both bits low answers, memory cycles only
    assign lin_sel_n = addr[12] || addr[13] || pins.io_m || !drv_en;

    // drive back only under the read strobe
    // Released lines show the inverse, so a stale sample is caught
    always_comb begin
        if (!pins.rd_n && drv_en) begin
            ad_i = pins.io_m ? io[addr[7:0]] : mem[addr];
        end else begin
            ad_i = ~last_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!pins.rd_n && drv_en) last_r <= ad_i;
        if (!pins.wr_n && drv_en) begin
            if (pins.io_m) io[addr[7:0]] <= pins.ad_o;
            else mem[addr] <= pins.ad_o;
        end
    end
endmodule

// File: sim/muxed_bus_split_and_decode_test.sv
// Self-checking bench for the multiplexed bus cycle generator
module muxed_bus_split_and_decode_test;
    timeunit 1ns;
    timeprecision 1ns;
    import bus_pkg::*;

    logic        ref_clk, rst_n, req_valid, req_ready, rsp_valid, wait_n;
    logic        bus_hold_request, bus_grant_ack, ale_io, lin_sel_n;
    logic [7:0]  rsp_rdata, ad_i, wr_data, rd_got, mem_sel_n;
    logic [8:0]  sel_seen;
    logic [15:0] ale_addr;
    req_t        req;
    pins_t       pins;
    int          error_cnt, num_checks, stb;

    muxed_bus_split_and_decode #(.HALF_T_CYC(1)) u_muxed_bus_split_and_decode (
        .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wait_n(wait_n),
        .bus_hold_request(bus_hold_request), .bus_grant_ack(bus_grant_ack),
        .ad_i(ad_i), .pins(pins));
    bus_partner u_bus_partner (
        .pins(pins), .ref_clk(ref_clk), .bus_grant_ack(bus_grant_ack), .ad_i(ad_i),
        .mem_sel_n(mem_sel_n), .lin_sel_n(lin_sel_n));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Pin snapshot per cycle
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (pins.ale) begin
            ale_addr = {pins.a_hi_o, pins.ad_o};
            ale_io = pins.io_m;
            stb = 0;
        end else if (!pins.rd_n || !pins.wr_n) begin
            stb = stb + 1;
            sel_seen = {lin_sel_n, mem_sel_n};
            if (!pins.wr_n) wr_data = pins.ad_o;
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task finish_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task xfer(input logic [15:0] a, input logic [7:0] d, input logic w, i, f);
        int n;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = '{addr: a, wdata: d, write: w, io: i, fetch: f};
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        rd_got = rsp_rdata;
        chk({15'h0, rsp_valid}, 16'h1);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_mem;
        xfer(16'h12a5, 8'h5e, 1'b1, 1'b0, 1'b0);
        chk(ale_addr, 16'h12a5);
        chk({15'h0, ale_io}, 16'h0);
        chk(stb[15:0], 16'h4);
        chk({8'h0, wr_data}, 16'h5e);
        chk({7'h0, sel_seen}, 16'h01ef);
        xfer(16'hffff, 8'ha1, 1'b1, 1'b0, 1'b0);
        xfer(16'h12a5, 8'h00, 1'b0, 1'b0, 1'b0);
        chk({8'h0, rd_got}, 16'h5e);
        chk(stb[15:0], 16'h4);
        xfer(16'hffff, 8'h00, 1'b0, 1'b0, 1'b0);
        chk(ale_addr, 16'hffff);
        chk({8'h0, rd_got}, 16'ha1);
    endtask

    task t_fetch;
        xfer(16'h12a5, 8'h00, 1'b0, 1'b0, 1'b1);
        chk(stb[15:0], 16'h3);
        chk({8'h0, rd_got}, 16'h5e);
    endtask

    task t_io;
        xfer(16'h773c, 8'hc3, 1'b1, 1'b1, 1'b0);
        chk(ale_addr, 16'h3c3c);
        chk({15'h0, ale_io}, 16'h1);
        chk(stb[15:0], 16'h6);
        // Port 04 doubles to an address inside the decoded memory space
        xfer(16'h0004, 8'h99, 1'b1, 1'b1, 1'b0);
        chk({7'h0, sel_seen}, 16'h01ff);
        // Fetch flag must not shorten an I/O strobe
        xfer(16'h003c, 8'h00, 1'b0, 1'b1, 1'b1);
        chk({8'h0, rd_got}, 16'hc3);
        chk(stb[15:0], 16'h6);
    endtask

    task t_decode;
        xfer(16'h4405, 8'h66, 1'b1, 1'b0, 1'b0);
        chk({7'h0, sel_seen}, 16'h00ff);
        xfer(16'h0405, 8'h77, 1'b1, 1'b0, 1'b0);
        chk({7'h0, sel_seen}, 16'h00fd);
        xfer(16'h0405, 8'h00, 1'b0, 1'b0, 1'b0);
        chk({8'h0, rd_got}, 16'h77);
        chk({7'h0, sel_seen}, 16'h00fd);
    endtask

    task t_wait;
        @(negedge ref_clk);
        wait_n = 1'b0;
        fork
            xfer(16'hffff, 8'h00, 1'b0, 1'b0, 1'b0);
            begin
                wait (pins.rd_n === 1'b0);
                repeat (5) @(negedge ref_clk);
                wait_n = 1'b1;
            end
        join
        chk(stb[15:0], 16'h6);
        chk({8'h0, rd_got}, 16'ha1);
    endtask

    task t_hold;
        @(negedge ref_clk);
        bus_hold_request = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({15'h0, bus_grant_ack}, 16'h1);
        chk({13'h0, pins.ad_oe, pins.a_hi_oe, pins.ctl_oe}, 16'h0);
        chk({15'h0, req_ready}, 16'h0);
        bus_hold_request = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({15'h0, bus_grant_ack}, 16'h0);
        chk({14'h0, pins.a_hi_oe, pins.ctl_oe}, 16'h3);
        xfer(16'h12a5, 8'h00, 1'b0, 1'b0, 1'b0);
        chk({8'h0, rd_got}, 16'h5e);
    endtask

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        wait_n = 1'b1;
        bus_hold_request = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        stb = 0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        t_mem;
        t_fetch;
        t_io;
        t_decode;
        t_wait;
        t_hold;
        finish_test;
    end

    // Whole run is well under two hundred cycles; this is far beyond
    initial begin
        #100000;
        error_cnt++;
        finish_test;
    end
endmodule
